// [rtl/dscg_pkg.sv]
// Shared constants and types for the deep-sleep clock gating block
package dscg_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] RUN_GATE_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h114;
  localparam logic [ADDR_W-1:0] DEEP_GATE_OFS = 12'h124;
  localparam logic [ADDR_W-1:0] CLOCK_CFG_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h200;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h204;
  localparam int unsigned GP_COUNTER0_BIT = 16;
  localparam int unsigned GP_COUNTER3_BIT = 19;
  localparam int unsigned ANALOG_COMPARATOR0_BIT = 24;
  localparam int unsigned TWO_WIRE0_BIT = 12;
  localparam int unsigned SYNC_SERIAL0_BIT = 4;
  localparam int unsigned SYNC_SERIAL1_BIT = 5;
  localparam int unsigned ASYNC_SERIAL0_BIT = 0;
  localparam int unsigned ASYNC_SERIAL2_BIT = 2;
  localparam int unsigned AUTO_CLOCK_GATING_ENABLE_BIT = 0;
  localparam logic [DATA_W-1:0] GATE_WRITABLE_MASK = 32'h010F1037;
  localparam logic [DATA_W-1:0] CLOCK_CFG_WRITABLE_MASK = 32'h00000001;
  localparam logic [DATA_W-1:0] GATE_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] CLOCK_CFG_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] IRQ_RESET = 32'h00000000;
  typedef enum logic [1:0] {
    PSTATE_RUN,
    PSTATE_SLEEP,
    PSTATE_DEEP
  } dscg_pstate_type;
endpackage

// [rtl/dscg_gate_select.sv]
// Chooses the gating word that applies in the current power state
`timescale 1ns/1ns
`default_nettype none
module dscg_gate_select (
  input wire dscg_pkg::dscg_pstate_type pstate, // Current power state
  input wire logic auto_gate, // Automatic gating enable
  input wire logic [31:0] run_gate, // Run-mode gating word
  input wire logic [31:0] sleep_gate, // Sleep-mode gating word
  input wire logic [31:0] deep_gate, // Deep-sleep gating word
  output logic [31:0] gate_select // Selected gating word
);
  always_comb
  begin
    case (pstate)
      dscg_pkg::PSTATE_RUN: gate_select = run_gate;
      // Without automatic gating the run word keeps governing in low power
      dscg_pkg::PSTATE_SLEEP: gate_select = auto_gate ? sleep_gate : run_gate;
      dscg_pkg::PSTATE_DEEP: gate_select = auto_gate ? deep_gate : run_gate;
      default: gate_select = run_gate;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/dscg_clock_gating.sv]
// Peripheral clock gating registers with APB access, bus fault flags and interrupt
`timescale 1ns/1ns
`default_nettype none
module dscg_clock_gating (
  input wire logic ref_clk, // System clock, 25 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic sleep_mode, // System is in sleep
  input wire logic deep_sleep_mode, // System is in deep-sleep
  input wire logic [31:0] unit_access, // Per-unit access strobe, gating layout
  output logic [31:0] unit_clock_enable, // Per-unit clock enable, gating layout
  output logic [31:0] unit_fault, // Per-unit bus fault pulse
  output logic irq // Level interrupt
);
  logic [31:0] run_clock_gate_group1;
  logic [31:0] sleep_clock_gate_group1;
  logic [31:0] deep_sleep_clock_gate_group1;
  logic [31:0] run_clock_configuration;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic [31:0] next_enable;
  logic [31:0] next_rdata;
  logic next_err;
  logic [31:0] fault_event;
  logic access_done;
  logic wr_done;
  dscg_pkg::dscg_pstate_type pstate;

  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = addr_hit(addr, dscg_pkg::RUN_GATE_OFS) || addr_hit(addr, dscg_pkg::SLEEP_GATE_OFS)
      || addr_hit(addr, dscg_pkg::DEEP_GATE_OFS) || addr_hit(addr, dscg_pkg::CLOCK_CFG_OFS)
      || addr_hit(addr, dscg_pkg::IRQ_STATUS_OFS) || addr_hit(addr, dscg_pkg::IRQ_MASK_OFS);
  endfunction

  // Deep-sleep wins if both mode inputs are high
  always_comb
  begin
    if (deep_sleep_mode)
      pstate = dscg_pkg::PSTATE_DEEP;
    else if (sleep_mode)
      pstate = dscg_pkg::PSTATE_SLEEP;
    else
      pstate = dscg_pkg::PSTATE_RUN;
  end

  dscg_gate_select u_select (
    .pstate(pstate),
    .auto_gate(run_clock_configuration[dscg_pkg::AUTO_CLOCK_GATING_ENABLE_BIT]),
    .run_gate(run_clock_gate_group1),
    .sleep_gate(sleep_clock_gate_group1),
    .deep_gate(deep_sleep_clock_gate_group1),
    .gate_select(next_enable)
  );

  // One wait state: pready rises in the second access cycle
  assign access_done = psel && penable && pready;
  assign wr_done = access_done && pwrite && addr_mapped(paddr);

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err = !addr_mapped(paddr);
    if (addr_hit(paddr, dscg_pkg::RUN_GATE_OFS))
      next_rdata = run_clock_gate_group1;
    else if (addr_hit(paddr, dscg_pkg::SLEEP_GATE_OFS))
      next_rdata = sleep_clock_gate_group1;
    else if (addr_hit(paddr, dscg_pkg::DEEP_GATE_OFS))
      next_rdata = deep_sleep_clock_gate_group1;
    else if (addr_hit(paddr, dscg_pkg::CLOCK_CFG_OFS))
      next_rdata = run_clock_configuration;
    else if (addr_hit(paddr, dscg_pkg::IRQ_STATUS_OFS))
      next_rdata = irq_status;
    else if (addr_hit(paddr, dscg_pkg::IRQ_MASK_OFS))
      next_rdata = irq_mask;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end
    else
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // Three gating words share one layout; reserved bits never store
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      run_clock_gate_group1 <= dscg_pkg::GATE_RESET;
      sleep_clock_gate_group1 <= dscg_pkg::GATE_RESET;
      deep_sleep_clock_gate_group1 <= dscg_pkg::GATE_RESET;
    end
    else if (wr_done)
    begin
      if (addr_hit(paddr, dscg_pkg::RUN_GATE_OFS))
        run_clock_gate_group1 <= pwdata & dscg_pkg::GATE_WRITABLE_MASK;
      if (addr_hit(paddr, dscg_pkg::SLEEP_GATE_OFS))
        sleep_clock_gate_group1 <= pwdata & dscg_pkg::GATE_WRITABLE_MASK;
      if (addr_hit(paddr, dscg_pkg::DEEP_GATE_OFS))
        deep_sleep_clock_gate_group1 <= pwdata & dscg_pkg::GATE_WRITABLE_MASK;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      run_clock_configuration <= dscg_pkg::CLOCK_CFG_RESET;
    else if (wr_done && addr_hit(paddr, dscg_pkg::CLOCK_CFG_OFS))
      run_clock_configuration <= pwdata & dscg_pkg::CLOCK_CFG_WRITABLE_MASK;
  end

  // Every unit starts unclocked until software enables it
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      unit_clock_enable <= dscg_pkg::GATE_RESET;
    else
      unit_clock_enable <= next_enable;
  end

  // Access to a gated unit raises a fault pulse one cycle later; the access itself is not blocked
  assign fault_event = unit_access & ~unit_clock_enable & dscg_pkg::GATE_WRITABLE_MASK;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      unit_fault <= 32'h00000000;
    else
      unit_fault <= fault_event;
  end

  // Sticky fault flags; a new fault in the clearing cycle is kept
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_status
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
          irq_status[i] <= 1'b0;
        else if (unit_fault[i])
          irq_status[i] <= 1'b1;
        else if (wr_done && addr_hit(paddr, dscg_pkg::IRQ_STATUS_OFS) && pwdata[i])
          irq_status[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      irq_mask <= dscg_pkg::IRQ_RESET;
    else if (wr_done && addr_hit(paddr, dscg_pkg::IRQ_MASK_OFS))
      irq_mask <= pwdata & dscg_pkg::GATE_WRITABLE_MASK;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  property p_run_gate_applies;
    @(posedge ref_clk) disable iff (!rstn)
    (!sleep_mode && !deep_sleep_mode) ##1 (!sleep_mode && !deep_sleep_mode && $stable(run_clock_gate_group1))
      |=> unit_clock_enable == $past(run_clock_gate_group1);
  endproperty
  a_run_gate_applies: assert property (p_run_gate_applies) else $error("run gating word not applied");

  property p_fault_on_gated;
    @(posedge ref_clk) disable iff (!rstn)
    (|(unit_access & ~unit_clock_enable & dscg_pkg::GATE_WRITABLE_MASK))
      |=> (unit_fault == ($past(unit_access) & ~$past(unit_clock_enable) & dscg_pkg::GATE_WRITABLE_MASK));
  endproperty
  a_fault_on_gated: assert property (p_fault_on_gated) else $error("gated access gave no fault");

  property p_no_fault_when_clocked;
    @(posedge ref_clk) disable iff (!rstn)
    (unit_access == unit_clock_enable) |=> unit_fault == 32'h00000000;
  endproperty
  a_no_fault_when_clocked: assert property (p_no_fault_when_clocked) else $error("fault on clocked unit");

  property p_reset_clears;
    @(posedge ref_clk)
    !rstn |=> (deep_sleep_clock_gate_group1 == 32'h00000000) && (unit_clock_enable == 32'h00000000);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("gating not cleared by reset");

  property p_reserved_read_zero;
    @(posedge ref_clk) disable iff (!rstn)
    (access_done && !pwrite && addr_hit(paddr, dscg_pkg::DEEP_GATE_OFS))
      |-> (prdata & ~dscg_pkg::GATE_WRITABLE_MASK) == 32'h00000000;
  endproperty
  a_reserved_read_zero: assert property (p_reserved_read_zero) else $error("reserved bits read nonzero");

  property p_deep_write;
    @(posedge ref_clk) disable iff (!rstn)
    (access_done && pwrite && addr_hit(paddr, dscg_pkg::DEEP_GATE_OFS))
      |=> deep_sleep_clock_gate_group1 == ($past(pwdata) & dscg_pkg::GATE_WRITABLE_MASK);
  endproperty
  a_deep_write: assert property (p_deep_write) else $error("deep-sleep word write lost");

  property p_sleep_write_keeps_deep;
    @(posedge ref_clk) disable iff (!rstn)
    (access_done && pwrite && addr_hit(paddr, dscg_pkg::SLEEP_GATE_OFS)) |=> $stable(deep_sleep_clock_gate_group1);
  endproperty
  a_sleep_write_keeps_deep: assert property (p_sleep_write_keeps_deep) else $error("registers not separate");

  property p_no_auto_uses_run;
    @(posedge ref_clk) disable iff (!rstn)
    ((sleep_mode || deep_sleep_mode) && !run_clock_configuration[dscg_pkg::AUTO_CLOCK_GATING_ENABLE_BIT])
      |=> unit_clock_enable == $past(run_clock_gate_group1);
  endproperty
  a_no_auto_uses_run: assert property (p_no_auto_uses_run) else $error("low-power word used without auto gating");

  property p_deep_auto_uses_deep;
    @(posedge ref_clk) disable iff (!rstn)
    (deep_sleep_mode && run_clock_configuration[dscg_pkg::AUTO_CLOCK_GATING_ENABLE_BIT])
      |=> unit_clock_enable == $past(deep_sleep_clock_gate_group1);
  endproperty
  a_deep_auto_uses_deep: assert property (p_deep_auto_uses_deep) else $error("deep-sleep word not applied");

  property p_sleep_auto_uses_sleep;
    @(posedge ref_clk) disable iff (!rstn)
    (sleep_mode && !deep_sleep_mode && run_clock_configuration[dscg_pkg::AUTO_CLOCK_GATING_ENABLE_BIT])
      |=> unit_clock_enable == $past(sleep_clock_gate_group1);
  endproperty
  a_sleep_auto_uses_sleep: assert property (p_sleep_auto_uses_sleep) else $error("sleep word not applied");

  // A fault must stick even when a clear lands in the same cycle
  property p_status_set_wins;
    @(posedge ref_clk) disable iff (!rstn)
    (|unit_fault) |=> (irq_status & $past(unit_fault)) == $past(unit_fault);
  endproperty
  a_status_set_wins: assert property (p_status_set_wins) else $error("fault flag not kept");

  property p_reserved_never_enabled;
    @(posedge ref_clk) disable iff (!rstn)
    1'b1 |-> (unit_clock_enable & ~dscg_pkg::GATE_WRITABLE_MASK) == 32'h00000000;
  endproperty
  a_reserved_never_enabled: assert property (p_reserved_never_enabled) else $error("reserved enable set");

  property p_error_only_with_ready;
    @(posedge ref_clk) disable iff (!rstn)
    pslverr |-> pready;
  endproperty
  a_error_only_with_ready: assert property (p_error_only_with_ready) else $error("APB error without ready");

  property p_irq_level;
    @(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> irq == $past(|(irq_status & irq_mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("masked-in fault gave no interrupt");

  property p_ready_one_wait;
    @(posedge ref_clk) disable iff (!rstn)
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_ready_one_wait: assert property (p_ready_one_wait) else $error("APB answer timing wrong");
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the deep-sleep clock gating block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_mode = 1'b0;
  logic deep_sleep_mode = 1'b0;
  logic [31:0] unit_access = 32'h00000000;
  logic [31:0] unit_clock_enable;
  logic [31:0] unit_fault;
  logic irq;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  // Comparator 24, counters 19:16, two-wire 12, sync serial 5:4, async serial 2:0
  localparam logic [31:0] ALL_GATES = 32'h010F1037;

  dscg_clock_gating uut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sleep_mode(sleep_mode),
    .deep_sleep_mode(deep_sleep_mode),
    .unit_access(unit_access),
    .unit_clock_enable(unit_clock_enable),
    .unit_fault(unit_fault),
    .irq(irq)
  );

  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the idle edge at the end keeps back-to-back calls from double driving psel
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // The wait ends when pready rises; if it never does, only the bench timeout ends it
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h00000000);
    check(rd, exp);
    check({31'h0, err}, 32'h00000000);
  endtask

  task automatic mode(input logic slp, input logic dp, input logic [31:0] exp);
    sleep_mode <= slp;
    deep_sleep_mode <= dp;
    repeat (3) @(posedge ref_clk);
    check(unit_clock_enable, exp);
  endtask

  task automatic t_reset();
    check(unit_clock_enable, 32'h00000000);
    rdchk(12'h124, 32'h00000000);
    rdchk(12'h104, 32'h00000000);
    rdchk(12'h114, 32'h00000000);
  endtask

  task automatic t_fields();
    apb(1'b1, 12'h124, 32'hFFFFFFFF);
    rdchk(12'h124, ALL_GATES);
    apb(1'b1, 12'h124, 32'h00000000);
    rdchk(12'h124, 32'h00000000);
    apb(1'b1, 12'h104, 32'h00000001);
    apb(1'b1, 12'h114, 32'h00000030);
    apb(1'b1, 12'h124, 32'h01000000);
    rdchk(12'h114, 32'h00000030);
  endtask

  task automatic t_select();
    mode(1'b0, 1'b1, 32'h00000001);
    mode(1'b1, 1'b0, 32'h00000001);
    apb(1'b1, 12'h060, 32'h00000001);
    mode(1'b0, 1'b0, 32'h00000001);
    mode(1'b1, 1'b0, 32'h00000030);
    mode(1'b1, 1'b1, 32'h01000000);
  endtask

  task automatic t_fault();
    unit_access <= 32'hFFFFFFFF;
    @(posedge ref_clk);
    unit_access <= 32'h00000000;
    #1 check(unit_fault, 32'h000F1037);
    @(posedge ref_clk);
    #1 check(unit_fault, 32'h00000000);
    @(posedge ref_clk);
    rdchk(12'h200, 32'h000F1037);
    check({31'h0, irq}, 32'h00000000);
    apb(1'b1, 12'h204, 32'h00010000);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h00000001);
    apb(1'b1, 12'h200, 32'h00010000);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h00000000);
    rdchk(12'h200, 32'h000E1037);
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h300, 32'hFFFFFFFF);
    check({31'h0, err}, 32'h00000001);
    apb(1'b0, 12'h300, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    check(rd, 32'h00000000);
    rdchk(12'h124, 32'h01000000);
  endtask

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_fields();
    t_select();
    t_fault();
    t_unmapped();
    complete_run();
  end
endmodule
`default_nettype wire
